// >>> include/dtp_pkg.sv
// Purpose: Shared constants for the dual 8-bit timer pair with pulse generator and cascade.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Offsets and field positions are fixed here and used by name everywhere.
package dtp_pkg;

    // -------------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0] OFS_PAIR_CTRL  = 8'h00; // Pair control register.
    localparam logic [7:0] OFS_LOW_MODE   = 8'h04; // Low channel mode register.
    localparam logic [7:0] OFS_HIGH_MODE  = 8'h08; // High channel mode register.
    localparam logic [7:0] OFS_LOW_CYCLE  = 8'h0c; // Low channel cycle compare.
    localparam logic [7:0] OFS_HIGH_CYCLE = 8'h10; // High channel cycle compare.
    localparam logic [7:0] OFS_LOW_DUTY   = 8'h14; // Low channel duty compare.
    localparam logic [7:0] OFS_HIGH_DUTY  = 8'h18; // High channel duty compare.
    localparam logic [7:0] OFS_STATUS     = 8'h1c; // Counters and outputs, read only.

    // -------------------------------------------------------------------------
    // Pair control fields
    // -------------------------------------------------------------------------
    localparam int CTL_LOW_RUN  = 0; // Low channel run bit.
    localparam int CTL_HIGH_RUN = 1; // High channel run bit.
    localparam int CTL_CASCADE  = 2; // Cascade select bit.
    localparam int CTL_AND      = 3; // Output combine and bit.

    // -------------------------------------------------------------------------
    // Mode register fields
    // -------------------------------------------------------------------------
    localparam int MOD_CLK_LSB  = 0; // Clock select, three bits.
    localparam int MOD_EXT      = 3; // External input select bit.
    localparam int MOD_OUT_LVL  = 4; // Initial output level bit.
    localparam int MOD_BUF_EN   = 5; // Buffer enable bit.
    localparam int MOD_OPM_LSB  = 6; // Operating mode field, two bits.

    localparam logic [1:0] OPM_PPG    = 2'h2; // Pulse generator mode code.
    localparam logic [1:0] OPM_TIMER0 = 2'h0; // Interval timer code one.
    localparam logic [1:0] OPM_TIMER1 = 2'h1; // Interval timer code two.

    // -------------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00; // Every register resets to zero.
    localparam int         PRE_W    = 12;    // Prescaler width.

endpackage

// >>> rtl/dtp_prescale.sv
// Purpose: Free running prescaler that yields a one-cycle tick per selected divide.
// Assumes: Clock select codes pick divide 2^11, 2^10, 2^8, 2^6, 2^4, 2^2, 2, 1.
// Notes:   Shared by both channels so their ticks stay phase aligned.
`timescale 1ns/1ps
module dtp_prescale
    import dtp_pkg::*;
(
    input  wire logic       ref_clk,    // System clock.
    input  wire logic       reset,      // Asynchronous reset, active high.
    input  wire logic [2:0] sel_a,      // Clock select for tick a.
    input  wire logic [2:0] sel_b,      // Clock select for tick b.
    output logic            tick_a,     // Count enable for a.
    output logic            tick_b      // Count enable for b.
);

    logic [PRE_W-1:0] div_q; // Divider chain.

    // Maps a select code to a rollover condition of the divider.
    function automatic logic hit(input logic [2:0] s, input logic [PRE_W-1:0] d);
        case (s)
            3'h0:    hit = &d[10:0];
            3'h1:    hit = &d[9:0];
            3'h2:    hit = &d[7:0];
            3'h3:    hit = &d[5:0];
            3'h4:    hit = &d[3:0];
            3'h5:    hit = &d[1:0];
            3'h6:    hit = d[0];
            default: hit = 1'b1;
        endcase
    endfunction

    // Divider counts every cycle.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick_a = hit(sel_a, div_q);
    assign tick_b = hit(sel_b, div_q);

endmodule

// >>> rtl/dtp_timer_pair.sv
// Purpose: Two 8-bit timers with pulse generator mode and a cascaded 16-bit timer.
// Assumes: APB slave, zero wait states; pready always high.
// Notes:   Operation
`timescale 1ns/1ps
module dtp_timer_pair
    import dtp_pkg::*;
(
    input  wire logic        ref_clk,          // System clock, 200 MHz.
    input  wire logic        reset,            // Asynchronous reset, active high.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB enable.
    input  wire logic        pwrite,           // APB direction.
    input  wire logic [7:0]  paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic [31:0]      prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error.
    output logic             pulse_output_pin, // Pulse output.
    output logic             low_channel_irq,  // Low channel interrupt pulse.
    output logic             high_channel_irq  // High channel interrupt pulse.
);

    // -------------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------------
    logic [3:0] ctrl_q;                 // Pair control register.
    logic [7:0] mode_q     [2];         // Mode registers, index 0 low, 1 high.
    logic [7:0] cyc_shd_q  [2];         // Cycle shadow, last written.
    logic [7:0] cyc_act_q  [2];         // Cycle active compare.
    logic [7:0] duty_shd_q [2];         // Duty shadow, last written.
    logic [7:0] duty_act_q [2];         // Duty active compare.
    logic [7:0] low_pend_q;             // Low byte waiting for high byte commit.
    logic [15:0] c16_shd_q;             // Combined shadow compare.
    logic [15:0] c16_act_q;             // Combined active compare.
    logic [7:0] cnt_q      [2];         // Up counters.
    logic [1:0] tff_q;                  // Channel flip-flop outputs.
    logic [1:0] irq_q;                  // Interrupt pulses.
    logic       pin_q;                  // Pin output register.
    logic [31:0] rdata_q;               // Registered read data.

    // -------------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------------
    logic        wr_en;        // Write access phase.
    logic        rd_en;        // Read access phase.
    logic        cascade;      // Cascade select.
    logic [1:0]  run;          // Run bits.
    logic [1:0]  ppg;          // Channel is in pulse generator mode.
    logic        t16;          // Cascaded interval timer active.
    logic [1:0]  tick;         // Count ticks.
    logic [15:0] cnt16;        // Combined count.
    logic [1:0]  duty_hit;     // Duty match.
    logic [1:0]  cyc_hit;      // Cycle match.
    logic        hit16;        // 16-bit match.
    logic        c16_wr;       // High cycle byte write that commits in cascade.
    logic [1:0]  cyc_wr;       // Cycle byte write per channel.
    logic [1:0]  duty_wr;      // Duty byte write per channel.

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign cascade = ctrl_q[CTL_CASCADE];
    assign run     = ctrl_q[CTL_HIGH_RUN:CTL_LOW_RUN];
    assign cnt16   = {cnt_q[1], cnt_q[0]};
    // Cascade timer: high mode 00 or 01 and internal clock.
    assign t16     = cascade && !mode_q[1][MOD_EXT] &&
                     ((mode_q[1][MOD_OPM_LSB+:2] == OPM_TIMER0) ||
                      (mode_q[1][MOD_OPM_LSB+:2] == OPM_TIMER1));
    assign hit16   = t16 && run[1] && tick[1] && (cnt16 == c16_act_q);
    assign c16_wr  = wr_en && (paddr == OFS_HIGH_CYCLE) && cascade;

    // Shared prescaler; the cascade uses the high channel's clock select.
    dtp_prescale u_pre (
        .ref_clk (ref_clk),
        .reset   (reset),
        .sel_a   (mode_q[0][MOD_CLK_LSB+:3]),
        .sel_b   (mode_q[1][MOD_CLK_LSB+:3]),
        .tick_a  (tick[0]),
        .tick_b  (tick[1])
    );

    // -------------------------------------------------------------------------
    // Per channel decode
    // -------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            // Pulse generator mode needs mode 10, no cascade, internal clock.
            assign ppg[g]      = (mode_q[g][MOD_OPM_LSB+:2] == OPM_PPG) && !cascade &&
                                 !mode_q[g][MOD_EXT];
            // Compare against the active value each tick.
            assign duty_hit[g] = ppg[g] && run[g] && tick[g] && (cnt_q[g] == duty_act_q[g]);
            assign cyc_hit[g]  = ppg[g] && run[g] && tick[g] && (cnt_q[g] == cyc_act_q[g]);
            assign cyc_wr[g]   = wr_en && (paddr == (g ? OFS_HIGH_CYCLE : OFS_LOW_CYCLE));
            assign duty_wr[g]  = wr_en && (paddr == (g ? OFS_HIGH_DUTY : OFS_LOW_DUTY));
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Control and mode registers
    // -------------------------------------------------------------------------
    // Mode writes are dropped while the owning channel runs.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q    <= '0;
            mode_q[0] <= RST_BYTE;
            mode_q[1] <= RST_BYTE;
        end
        else
        begin
            if (wr_en && paddr == OFS_PAIR_CTRL)
            begin
                ctrl_q <= pwdata[3:0];
            end
            if (wr_en && paddr == OFS_LOW_MODE && !run[0])
            begin
                mode_q[0] <= pwdata[7:0];
            end
            if (wr_en && paddr == OFS_HIGH_MODE && !run[1])
            begin
                mode_q[1] <= pwdata[7:0];
            end
        end
    end

    // -------------------------------------------------------------------------
    // 8-bit compare registers with optional double buffer
    // -------------------------------------------------------------------------
    // Shadows always hold the last write; active loads now or at the cycle irq.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 2; i++)
            begin
                cyc_shd_q[i]  <= RST_BYTE;
                cyc_act_q[i]  <= RST_BYTE;
                duty_shd_q[i] <= RST_BYTE;
                duty_act_q[i] <= RST_BYTE;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                // Buffered and running: swap in shadows on the cycle irq.
                if (mode_q[i][MOD_BUF_EN] && run[i] && cyc_hit[i])
                begin
                    cyc_act_q[i]  <= cyc_shd_q[i];
                    duty_act_q[i] <= duty_shd_q[i];
                end
                if (cyc_wr[i])
                begin
                    cyc_shd_q[i] <= pwdata[7:0];
                    // Unbuffered or stopped: active updates at once.
                    if (!mode_q[i][MOD_BUF_EN] || !run[i])
                    begin
                        cyc_act_q[i] <= pwdata[7:0];
                    end
                end
                if (duty_wr[i])
                begin
                    duty_shd_q[i] <= pwdata[7:0];
                    if (!mode_q[i][MOD_BUF_EN] || !run[i])
                    begin
                        duty_act_q[i] <= pwdata[7:0];
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // 16-bit compare with low-then-high commit
    // -------------------------------------------------------------------------
    // Low byte waits; the high byte write commits both bytes together.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            low_pend_q <= RST_BYTE;
            c16_shd_q  <= '0;
            c16_act_q  <= '0;
        end
        else
        begin
            if (cyc_wr[0])
            begin
                low_pend_q <= pwdata[7:0];
            end
            if (hit16 && mode_q[1][MOD_BUF_EN])
            begin
                c16_act_q <= c16_shd_q;
            end
            if (c16_wr)
            begin
                c16_shd_q <= {pwdata[7:0], low_pend_q};
                if (!mode_q[1][MOD_BUF_EN] || !run[1])
                begin
                    c16_act_q <= {pwdata[7:0], low_pend_q};
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Counters
    // -------------------------------------------------------------------------
    // Counters tick when running in pulse generator or cascade timer mode, clear on match or stop.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_q[0] <= RST_BYTE;
            cnt_q[1] <= RST_BYTE;
        end
        else if (t16)
        begin
            if (!run[1] || hit16)
            begin
                {cnt_q[1], cnt_q[0]} <= '0;
            end
            else if (tick[1])
            begin
                {cnt_q[1], cnt_q[0]} <= cnt16 + 16'h0001;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!run[i] || cyc_hit[i])
                begin
                    cnt_q[i] <= RST_BYTE;
                end
                else if (tick[i] && ppg[i])
                begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Output flip-flops and interrupts
    // -------------------------------------------------------------------------
    // Duty match inverts, cycle match returns to idle; stopped shows idle.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tff_q <= '0;
            irq_q <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!run[i] || cyc_hit[i])
                begin
                    tff_q[i] <= mode_q[i][MOD_OUT_LVL];
                end
                else if (duty_hit[i])
                begin
                    tff_q[i] <= !mode_q[i][MOD_OUT_LVL];
                end
            end
            irq_q[0] <= cyc_hit[0];
            irq_q[1] <= cyc_hit[1] || hit16;
        end
    end

    // Pin shows the low channel, or the AND of both when combined.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_q <= 1'b0;
        end
        else
        begin
            pin_q <= ctrl_q[CTL_AND] ? (tff_q[0] & tff_q[1]) : tff_q[0];
        end
    end

    // -------------------------------------------------------------------------
    // APB read path
    // -------------------------------------------------------------------------
    // Compare reads return the last value written.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_q <= '0;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFS_PAIR_CTRL:  rdata_q <= {28'h0000000, ctrl_q};
                OFS_LOW_MODE:   rdata_q <= {24'h000000, mode_q[0]};
                OFS_HIGH_MODE:  rdata_q <= {24'h000000, mode_q[1]};
                OFS_LOW_CYCLE:  rdata_q <= {24'h000000, cyc_shd_q[0]};
                OFS_HIGH_CYCLE: rdata_q <= {24'h000000, cyc_shd_q[1]};
                OFS_LOW_DUTY:   rdata_q <= {24'h000000, duty_shd_q[0]};
                OFS_HIGH_DUTY:  rdata_q <= {24'h000000, duty_shd_q[1]};
                OFS_STATUS:     rdata_q <= {14'h0000, tff_q, cnt_q[1], cnt_q[0]};
                default:        rdata_q <= '0;
            endcase
        end
    end

    assign prdata           = rdata_q;
    assign pready           = 1'b1;
    assign pslverr          = 1'b0;
    assign pulse_output_pin = pin_q;
    assign low_channel_irq  = irq_q[0];
    assign high_channel_irq = irq_q[1];

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    property p_stop_clears;
        @(posedge ref_clk) disable iff (reset)
        (!run[0] && !t16) |=> (cnt_q[0] == 8'h00);
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stopped counter not zero");

    property p_idle_level;
        @(posedge ref_clk) disable iff (reset)
        (!run[0] && !ctrl_q[CTL_AND]) [*2] |=> (pulse_output_pin == $past(mode_q[0][MOD_OUT_LVL], 2));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("stopped pin not idle");

    property p_cyc_irq;
        @(posedge ref_clk) disable iff (reset)
        cyc_hit[0] |=> low_channel_irq;
    endproperty
    a_cyc_irq: assert property (p_cyc_irq) else $error("cycle match lacks irq");

    property p_mode_lock;
        @(posedge ref_clk) disable iff (reset)
        run[0] && $past(run[0]) |-> $stable(mode_q[0]);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("mode changed while running");

    property p_duty_flip;
        @(posedge ref_clk) disable iff (reset)
        (duty_hit[0] && !cyc_hit[0]) |=> (tff_q[0] != mode_q[0][MOD_OUT_LVL]);
    endproperty
    a_duty_flip: assert property (p_duty_flip) else $error("duty match no invert");

    property p_hit16;
        @(posedge ref_clk) disable iff (reset)
        hit16 |=> (cnt16 == 16'h0000) && high_channel_irq;
    endproperty
    a_hit16: assert property (p_hit16) else $error("16-bit match no clear");

    property p_c16_now;
        @(posedge ref_clk) disable iff (reset)
        (c16_wr && !run[1]) |=> (c16_act_q == c16_shd_q);
    endproperty
    a_c16_now: assert property (p_c16_now) else $error("stopped 16-bit write not applied");

    property p_buf_hold;
        @(posedge ref_clk) disable iff (reset)
        (duty_wr[0] && run[0] && mode_q[0][MOD_BUF_EN] && !cyc_hit[0]) |=> $stable(duty_act_q[0]);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("buffered write applied early");

endmodule

// >>> test/dtp_timer_pair_tb.sv
// Purpose: Self-checking bench for the dual timer pair, driven over APB.
// Assumes: Clock select 7 gives one count per ref_clk cycle.
// Notes:   Interrupt spacing and pin levels are judged against the compare values.
`timescale 1ns/1ps
module testbench;
    import dtp_pkg::*;
    logic        ref_clk = 1'b0;  // System clock, 5 ns period.
    logic        reset   = 1'b1;  // Held for 20 cycles at start.
    logic        psel    = 1'b0;  // APB select.
    logic        penable = 1'b0;  // APB enable.
    logic        pwrite  = 1'b0;  // APB direction.
    logic [7:0]  paddr   = 8'h00; // APB address.
    logic [31:0] pwdata  = 32'h0; // APB write data.
    logic [31:0] prdata;          // APB read data.
    logic [31:0] rd;              // Last word read.
    logic        pready;          // APB ready.
    logic        pslverr;         // APB error, unused.
    logic        pin;             // Pulse output.
    logic        irq_lo;          // Low channel interrupt.
    logic        irq_hi;          // High channel interrupt.
    int          mismatches = 0;  // Failed comparisons.
    int          n_tests    = 0;  // All comparisons.
    int          w, n, a;         // Wait, interval and active-level counts.

    always #2.5 ref_clk = ~ref_clk;

    dtp_timer_pair dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_output_pin(pin), .low_channel_irq(irq_lo),
        .high_channel_irq(irq_hi));

    // Builds a mode word with the fastest clock select.
    function automatic logic [31:0] md(input logic [1:0] opm, input logic bf, input logic lv);
        md = (32'(opm) << MOD_OPM_LSB) | (32'(bf) << MOD_BUF_EN) | (32'(lv) << MOD_OUT_LVL) | 32'h7;
    endfunction

    // Compares and counts; an unknown never matches.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for an interrupt, then counts cycles and non-idle pin cycles to the next.
    task automatic gap(input logic hi, input logic idle);
        w = 0;
        n = 0;
        a = 0;
        do begin @(posedge ref_clk); #1; w++; end
        while ((hi ? irq_hi : irq_lo) !== 1'b1 && w < 3000);
        do begin @(posedge ref_clk); #1; n++; if (pin !== idle) a++; end
        while ((hi ? irq_hi : irq_lo) !== 1'b1 && n < 3000);
        // A missing interrupt is a failure in its own right.
        if (w >= 3000 || n >= 3000)
        begin
            mismatches++;
            $display("unexpected at %0t: interrupt timeout", $time);
        end
    endtask

    task automatic t_idle;
        apb(1'b1, OFS_LOW_MODE, md(OPM_PPG, 1'b0, 1'b0));
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h0, "idle level low");
        apb(1'b1, OFS_LOW_MODE, md(OPM_PPG, 1'b0, 1'b1));
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h1, "idle level high");
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0, "unmapped read");
    endtask

    task automatic t_ppg;
        apb(1'b1, OFS_LOW_CYCLE, 32'h5);
        apb(1'b1, OFS_LOW_DUTY, 32'h2);
        apb(1'b1, OFS_PAIR_CTRL, 32'h1 << CTL_LOW_RUN);
        gap(1'b0, 1'b1);
        chk(32'(n), 32'h6, "pulse period");
        chk(32'(a), 32'h3, "pulse width");
        // Unbuffered running write: the longer cycle applies to the current period.
        apb(1'b1, OFS_LOW_CYCLE, 32'h8);
        gap(1'b0, 1'b1);
        chk(32'(w), 32'h6, "unbuffered cycle write at once");
        chk(32'(n), 32'h9, "new cycle length");
        apb(1'b1, OFS_LOW_MODE, md(OPM_PPG, 1'b0, 1'b0));
        apb(1'b0, OFS_LOW_MODE, 32'h0);
        chk(rd, md(OPM_PPG, 1'b0, 1'b1), "mode changed while running");
        apb(1'b1, OFS_PAIR_CTRL, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h1, "stop level");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[7:0]), 32'h0, "stop count");
    endtask

    task automatic t_buf;
        apb(1'b1, OFS_LOW_MODE, md(OPM_PPG, 1'b1, 1'b0));
        apb(1'b1, OFS_LOW_CYCLE, 32'h5);
        apb(1'b1, OFS_PAIR_CTRL, 32'h1 << CTL_LOW_RUN);
        gap(1'b0, 1'b0);
        chk(32'(n), 32'h6, "stopped buffered write");
        apb(1'b1, OFS_LOW_CYCLE, 32'h9);
        gap(1'b0, 1'b0);
        chk(32'(w < 6), 32'h1, "old cycle kept until interrupt");
        chk(32'(n), 32'ha, "shadow loaded at interrupt");
        apb(1'b1, OFS_LOW_DUTY, 32'h4);
        apb(1'b0, OFS_LOW_DUTY, 32'h0);
        chk(rd, 32'h4, "duty shadow readback");
        apb(1'b0, OFS_LOW_CYCLE, 32'h0);
        chk(rd, 32'h9, "shadow readback");
        apb(1'b1, OFS_PAIR_CTRL, 32'h0);
    endtask

    task automatic t_and;
        apb(1'b1, OFS_LOW_MODE, md(OPM_PPG, 1'b0, 1'b1));
        apb(1'b1, OFS_HIGH_MODE, md(OPM_PPG, 1'b0, 1'b0));
        apb(1'b1, OFS_PAIR_CTRL, (32'h1 << CTL_LOW_RUN) | (32'h1 << CTL_AND));
        a = 0;
        repeat (30) begin @(posedge ref_clk); #1; if (pin !== 1'b0) a++; end
        chk(32'(a), 32'h0, "combined output");
        apb(1'b1, OFS_PAIR_CTRL, 32'h0);
    endtask

    // Both interval timer codes; compare is 0x0103, so 0x104 cycles apart.
    // The second pass is buffered; a running write of 0x0007 then shows when it lands.
    task automatic t_casc;
        apb(1'b1, OFS_PAIR_CTRL, 32'h1 << CTL_CASCADE);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, OFS_HIGH_MODE, md(i ? OPM_TIMER1 : OPM_TIMER0, i == 1, 1'b0));
            apb(1'b1, OFS_LOW_CYCLE, 32'h3);
            apb(1'b1, OFS_HIGH_CYCLE, 32'h1);
            apb(1'b1, OFS_PAIR_CTRL, (32'h1 << CTL_CASCADE) | (32'h1 << CTL_HIGH_RUN));
            gap(1'b1, 1'b0);
            chk(32'(n), 32'h104, "cascade interval");
            apb(1'b1, OFS_LOW_CYCLE, 32'h7);
            apb(1'b1, OFS_HIGH_CYCLE, 32'h0);
            gap(1'b1, 1'b0);
            chk(32'(w), i ? 32'hfe : 32'h2, "running compare write timing");
            chk(32'(n), 32'h8, "new cascade interval");
            apb(1'b1, OFS_PAIR_CTRL, 32'h1 << CTL_CASCADE);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(32'(rd[15:0]), 32'h0, "cascade stop count");
        end
        apb(1'b0, OFS_LOW_CYCLE, 32'h0);
        chk(rd, 32'h7, "low byte readback");
        apb(1'b0, OFS_HIGH_CYCLE, 32'h0);
        chk(rd, 32'h0, "high byte readback");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog at 20000 cycles, ten times the couple of thousand the tests need.
    initial
    begin
        #100000;
        mismatches++;
        results;
    end

    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_idle;
        t_ppg;
        t_buf;
        t_and;
        t_casc;
        results;
    end
endmodule
